//--- common/clk_out_cfg_pkg.sv
// Purpose: Shared constants for the output channel configuration block.
// Assumes: 16-bit registers reached over a 32-bit serial frame.
// Notes: Reserved register bits are not stored and read back as zero.
package clk_out_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (register numbers on the serial port)
  // ----------------------------------------------------------------
  localparam logic [14:0] PAIR01_INTEGER_DIVIDER_OFS = 15'h0006;
  localparam logic [14:0] PAIR23_DRIVER_CONTROL_OFS = 15'h0007;
  localparam logic [14:0] PAIR23_INTEGER_DIVIDER_OFS = 15'h0008;
  localparam logic [14:0] CHAN4_OUTPUT_CONTROL_OFS = 15'h0009;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DIV_MSB = 7;
  localparam int SUPPLY_POS = 0;
  localparam int EN_LO_POS = 1;
  localparam int DRV_LO_POS = 3;
  localparam int CH3_EN_LO_POS = 5;
  localparam int CH3_DRV_LO_POS = 7;
  localparam int POS_SIDE_POS = 6;
  localparam int NEG_SIDE_POS = 7;
  localparam int EDGE_RATE_POS = 8;
  localparam int FRAC_EN_POS = 9;
  localparam int PREDIV_LO_POS = 10;
  localparam int SRC_LO_POS = 13;

  // Writable bit masks; all other bits are reserved
  localparam logic [15:0] DIV_MASK = 16'h00FF;
  localparam logic [15:0] CTL23_MASK = 16'h01FF;
  localparam logic [15:0] CTL4_MASK = 16'h7FDF;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [1:0] EN_OFF = 2'h0;
  localparam logic [1:0] EN_CLOCK = 2'h1;
  localparam logic [1:0] EN_LOW = 2'h2;
  localparam logic [1:0] EN_HIGH = 2'h3;
  localparam logic [1:0] DRV_LVDS = 2'h0;
  localparam logic [1:0] DRV_ALT_LVDS = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h0;
  localparam logic [1:0] SRC_PRI = 2'h1;
  localparam logic [1:0] SRC_SEC = 2'h2;
  localparam logic [2:0] PREDIV_BY2 = 3'h0;
  localparam logic [2:0] PREDIV_BY3 = 3'h1;
  localparam logic [2:0] PREDIV_BY1 = 3'h7;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam logic [5:0] FRAME_LAST = 6'h1F;
  localparam logic [5:0] CMD_LAST = 6'h0F;
  localparam int FRAC_W = 20;

endpackage : clk_out_cfg_pkg

//--- src/clk_out_cfg.sv
// Purpose: Output channel 0..4 divider and driver configuration with serial register access.
// Assumes: Serial clock half period of at least four clk_i cycles; clk_i is the PLL path.
// Notes: Frame is 32 bits, MSB first: read flag, 15-bit register number, 16-bit data.
`timescale 1ns/100ps

module clk_out_cfg (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic pri_ref_i,
  input wire logic sec_ref_i,
  input wire logic [19:0] chan4_frac_value_i,
  output logic pair_a_clk_o,
  output logic chan2_o,
  output logic chan2_oe_o,
  output logic [1:0] chan2_driver_type_o,
  output logic chan3_o,
  output logic chan3_oe_o,
  output logic [1:0] chan3_driver_type_o,
  output logic pair_b_supply_select_o,
  output logic chan4_pos_o,
  output logic chan4_pos_oe_o,
  output logic chan4_neg_o,
  output logic chan4_neg_oe_o,
  output logic [1:0] chan4_driver_type_o,
  output logic chan4_edge_rate_o,
  output logic chan4_supply_select_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Integer divider step: wraps after value+1 ticks
  function automatic logic [8:0] div_step(input logic [7:0] cnt, input logic [7:0] lim);
    logic [8:0] r;
    r = (cnt == lim) ? {1'b1, 8'h00} : {1'b0, 8'(cnt + 8'h01)};
    return r;
  endfunction : div_step

  // Output level and enable from a two-bit enable code and the clock
  function automatic logic [1:0] chan_drive(input logic [1:0] en, input logic clk);
    logic [1:0] r;
    if (en == clk_out_cfg_pkg::EN_CLOCK) begin
      r = {clk, 1'b1};
    end else if (en == clk_out_cfg_pkg::EN_LOW) begin
      r = 2'h1;
    end else if (en == clk_out_cfg_pkg::EN_HIGH) begin
      r = 2'h3;
    end else begin
      r = 2'h0;
    end
    return r;
  endfunction : chan_drive

  // Folds the second LVDS-like code onto the first
  function automatic logic [1:0] drv_norm(input logic [1:0] code);
    return (code == clk_out_cfg_pkg::DRV_ALT_LVDS) ? clk_out_cfg_pkg::DRV_LVDS : code;
  endfunction : drv_norm

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [2:0] edge_q;
  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic pri_s;
  logic sec_s;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 5'h02;
      pin_s2_q <= 5'h02;
      edge_q <= 3'h0;
    end else begin
      // Two stages for every pin; select idles high
      pin_s1_q <= {sec_ref_i, pri_ref_i, spi_mosi_i, spi_cs_n_i, spi_sclk_i};
      pin_s2_q <= pin_s1_q;
      edge_q <= {sec_s, pri_s, sclk_s};
    end
  end
  assign sclk_s = pin_s2_q[0];
  assign cs_n_s = pin_s2_q[1];
  assign mosi_s = pin_s2_q[2];
  assign pri_s = pin_s2_q[3];
  assign sec_s = pin_s2_q[4];

  logic sclk_rise;
  logic sclk_fall;
  logic pri_tick;
  logic sec_tick;
  assign sclk_rise = sclk_s & ~edge_q[0];
  assign sclk_fall = ~sclk_s & edge_q[0];
  assign pri_tick = pri_s & ~edge_q[1];
  assign sec_tick = sec_s & ~edge_q[2];

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  logic [15:0] div01_q, div01_d;
  logic [15:0] ctl23_q, ctl23_d;
  logic [15:0] div23_q, div23_d;
  logic [15:0] ctl4_q, ctl4_d;
  logic [31:0] sh_q, sh_d;
  logic [5:0] bit_q, bit_d;
  logic [15:0] rd_q, rd_d;
  logic rd_act_q, rd_act_d;
  logic miso_q, miso_d;

  function automatic logic [15:0] reg_read(input logic [14:0] a, input logic [15:0] r6,
                                           input logic [15:0] r7, input logic [15:0] r8,
                                           input logic [15:0] r9);
    logic [15:0] v;
    if (a == clk_out_cfg_pkg::PAIR01_INTEGER_DIVIDER_OFS) begin
      v = r6;
    end else if (a == clk_out_cfg_pkg::PAIR23_DRIVER_CONTROL_OFS) begin
      v = r7;
    end else if (a == clk_out_cfg_pkg::PAIR23_INTEGER_DIVIDER_OFS) begin
      v = r8;
    end else if (a == clk_out_cfg_pkg::CHAN4_OUTPUT_CONTROL_OFS) begin
      v = r9;
    end else begin
      v = 16'h0000;
    end
    return v;
  endfunction : reg_read

  always_comb begin
    logic [31:0] word;
    word = {sh_q[30:0], mosi_s};
    div01_d = div01_q;
    ctl23_d = ctl23_q;
    div23_d = div23_q;
    ctl4_d = ctl4_q;
    sh_d = sh_q;
    bit_d = bit_q;
    rd_d = rd_q;
    rd_act_d = rd_act_q;
    miso_d = miso_q;
    if (cs_n_s) begin
      bit_d = 6'h00;
      rd_act_d = 1'b0;
    end else if (sclk_rise) begin
      sh_d = word;
      bit_d = 6'(bit_q + 6'h01);
      if (bit_q == clk_out_cfg_pkg::CMD_LAST && word[15]) begin
        rd_d = reg_read(word[14:0], div01_q, ctl23_q, div23_q, ctl4_q);
        rd_act_d = 1'b1;
      end
      if (bit_q == clk_out_cfg_pkg::FRAME_LAST && !word[31]) begin
        if (word[30:16] == clk_out_cfg_pkg::PAIR01_INTEGER_DIVIDER_OFS) begin
          div01_d = word[15:0] & clk_out_cfg_pkg::DIV_MASK;
        end else if (word[30:16] == clk_out_cfg_pkg::PAIR23_DRIVER_CONTROL_OFS) begin
          ctl23_d = word[15:0] & clk_out_cfg_pkg::CTL23_MASK;
        end else if (word[30:16] == clk_out_cfg_pkg::PAIR23_INTEGER_DIVIDER_OFS) begin
          div23_d = word[15:0] & clk_out_cfg_pkg::DIV_MASK;
        end else if (word[30:16] == clk_out_cfg_pkg::CHAN4_OUTPUT_CONTROL_OFS) begin
          ctl4_d = word[15:0] & clk_out_cfg_pkg::CTL4_MASK;
        end
      end
    end else if (sclk_fall && rd_act_q) begin
      miso_d = rd_q[15];
      rd_d = {rd_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div01_q <= clk_out_cfg_pkg::REG_RESET;
      ctl23_q <= clk_out_cfg_pkg::REG_RESET;
      div23_q <= clk_out_cfg_pkg::REG_RESET;
      ctl4_q <= clk_out_cfg_pkg::REG_RESET;
      sh_q <= 32'h00000000;
      bit_q <= 6'h00;
      rd_q <= 16'h0000;
      rd_act_q <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      div01_q <= div01_d;
      ctl23_q <= ctl23_d;
      div23_q <= div23_d;
      ctl4_q <= ctl4_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      rd_q <= rd_d;
      rd_act_q <= rd_act_d;
      miso_q <= miso_d;
    end
  end

  // ----------------------------------------------------------------
  // Clock path: pair dividers and channel 4 source
  // ----------------------------------------------------------------
  logic [7:0] cnt01_q, cnt01_d;
  logic [7:0] cnt23_q, cnt23_d;
  logic tick01, tick23;
  logic [1:0] pre_q, pre_d;
  logic [19:0] acc_q, acc_d;
  logic src_tick, pre_tick, frac_tick;
  logic [1:0] src_sel;
  logic [2:0] prediv;

  assign src_sel = ctl4_q[clk_out_cfg_pkg::SRC_LO_POS +: 2];
  assign prediv = ctl4_q[clk_out_cfg_pkg::PREDIV_LO_POS +: 3];

  always_comb begin
    logic [8:0] s01;
    logic [8:0] s23;
    logic [1:0] pre_lim;
    logic [20:0] sum;
    pre_lim = 2'h1;
    sum = {1'b0, acc_q} + {1'b0, chan4_frac_value_i};
    s01 = div_step(cnt01_q, div01_q[clk_out_cfg_pkg::DIV_MSB:0]);
    s23 = div_step(cnt23_q, div23_q[clk_out_cfg_pkg::DIV_MSB:0]);
    cnt01_d = s01[7:0];
    cnt23_d = s23[7:0];
    tick01 = s01[8];
    tick23 = s23[8];
    if (src_sel == clk_out_cfg_pkg::SRC_PRI) begin
      src_tick = pri_tick;
    end else if (src_sel == clk_out_cfg_pkg::SRC_SEC) begin
      src_tick = sec_tick;
    end else begin
      src_tick = 1'b1;
    end
    if (prediv == clk_out_cfg_pkg::PREDIV_BY3) begin
      pre_lim = 2'h2;
    end else if (prediv == clk_out_cfg_pkg::PREDIV_BY1) begin
      pre_lim = 2'h0;
    end
    pre_d = pre_q;
    pre_tick = 1'b0;
    if (src_tick) begin
      pre_tick = (pre_q >= pre_lim);
      pre_d = pre_tick ? 2'h0 : 2'(pre_q + 2'h1);
    end
    acc_d = acc_q;
    frac_tick = 1'b0;
    if (ctl4_q[clk_out_cfg_pkg::FRAC_EN_POS]) begin
      if (pre_tick) begin
        acc_d = sum[19:0];
        frac_tick = sum[20];
      end
    end else begin
      pre_d = 2'h0;
      acc_d = 20'h00000;
      frac_tick = src_tick;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt01_q <= 8'h00;
      cnt23_q <= 8'h00;
      pre_q <= 2'h0;
      acc_q <= 20'h00000;
    end else begin
      cnt01_q <= cnt01_d;
      cnt23_q <= cnt23_d;
      pre_q <= pre_d;
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------------------------------
  // Output drivers (all outputs registered)
  // ----------------------------------------------------------------
  logic [1:0] ch2_d, ch3_d, ch4_d;
  logic [1:0] drv2_d, drv3_d, drv4_d;
  logic neg_ok;

  always_comb begin
    // both pair channels share one tick
    ch2_d = chan_drive(ctl23_q[clk_out_cfg_pkg::EN_LO_POS +: 2], tick23);
    ch3_d = chan_drive(ctl23_q[clk_out_cfg_pkg::CH3_EN_LO_POS +: 2], tick23);
    ch4_d = chan_drive(ctl4_q[clk_out_cfg_pkg::EN_LO_POS +: 2], frac_tick);
    drv2_d = drv_norm(ctl23_q[clk_out_cfg_pkg::DRV_LO_POS +: 2]);
    drv3_d = drv_norm(ctl23_q[clk_out_cfg_pkg::CH3_DRV_LO_POS +: 2]);
    drv4_d = drv_norm(ctl4_q[clk_out_cfg_pkg::DRV_LO_POS +: 2]);
    neg_ok = ctl4_q[clk_out_cfg_pkg::NEG_SIDE_POS] & ctl4_q[clk_out_cfg_pkg::POS_SIDE_POS];
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
      pair_a_clk_o <= 1'b0;
      chan2_o <= 1'b0;
      chan2_oe_o <= 1'b0;
      chan2_driver_type_o <= 2'h0;
      chan3_o <= 1'b0;
      chan3_oe_o <= 1'b0;
      chan3_driver_type_o <= 2'h0;
      pair_b_supply_select_o <= 1'b0;
      chan4_pos_o <= 1'b0;
      chan4_pos_oe_o <= 1'b0;
      chan4_neg_o <= 1'b0;
      chan4_neg_oe_o <= 1'b0;
      chan4_driver_type_o <= 2'h0;
      chan4_edge_rate_o <= 1'b0;
      chan4_supply_select_o <= 1'b0;
    end else begin
      spi_miso_o <= miso_d;
      spi_miso_oe_o <= rd_act_d;
      pair_a_clk_o <= tick01;
      chan2_o <= ch2_d[1];
      chan2_oe_o <= ch2_d[0];
      chan2_driver_type_o <= drv2_d;
      chan3_o <= ch3_d[1];
      chan3_oe_o <= ch3_d[0];
      chan3_driver_type_o <= drv3_d;
      pair_b_supply_select_o <= ctl23_q[clk_out_cfg_pkg::SUPPLY_POS];
      chan4_pos_o <= ch4_d[1] & ctl4_q[clk_out_cfg_pkg::POS_SIDE_POS];
      chan4_pos_oe_o <= ch4_d[0] & ctl4_q[clk_out_cfg_pkg::POS_SIDE_POS];
      chan4_neg_o <= ch4_d[1] & neg_ok;
      chan4_neg_oe_o <= ch4_d[0] & neg_ok;
      chan4_driver_type_o <= drv4_d;
      chan4_edge_rate_o <= ctl4_q[clk_out_cfg_pkg::EDGE_RATE_POS];
      chan4_supply_select_o <= ctl4_q[clk_out_cfg_pkg::SUPPLY_POS];
    end
  end

endmodule : clk_out_cfg

//--- dv/clk_out_cfg_properties.sv
// Purpose: Port-level properties of the output channel configuration block.
// Assumes: One clock domain; reset is active low.
// Notes: Bound into every clk_out_cfg instance.
`timescale 1ns/100ps
module clk_out_cfg_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_oe_o,
  input wire logic chan2_o,
  input wire logic chan2_oe_o,
  input wire logic [1:0] chan2_driver_type_o,
  input wire logic chan3_o,
  input wire logic chan3_oe_o,
  input wire logic [1:0] chan3_driver_type_o,
  input wire logic pair_b_supply_select_o,
  input wire logic chan4_pos_o,
  input wire logic chan4_pos_oe_o,
  input wire logic chan4_neg_o,
  input wire logic chan4_neg_oe_o,
  input wire logic [1:0] chan4_driver_type_o,
  input wire logic chan4_edge_rate_o,
  input wire logic chan4_supply_select_o
);
  // ----------------------------------------
  // Output relations
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_chan2_level;
    chan2_o |-> chan2_oe_o;
  endproperty
  a_chan2_level: assert property (p_chan2_level)
    else $error("chan2 high while undriven");
  property p_chan3_level;
    chan3_o |-> chan3_oe_o;
  endproperty
  a_chan3_level: assert property (p_chan3_level)
    else $error("chan3 high while undriven");
  property p_chan4_level;
    chan4_pos_o |-> chan4_pos_oe_o;
  endproperty
  a_chan4_level: assert property (p_chan4_level)
    else $error("chan4 high while undriven");
  property p_neg_side;
    (chan4_neg_o || chan4_neg_oe_o) |->
      (chan4_pos_oe_o && chan4_neg_oe_o && chan4_neg_o == chan4_pos_o);
  endproperty
  a_neg_side: assert property (p_neg_side)
    else $error("negative side active without positive side");
  property p_chan2_type;
    chan2_driver_type_o != clk_out_cfg_pkg::DRV_ALT_LVDS;
  endproperty
  a_chan2_type: assert property (p_chan2_type)
    else $error("chan2 type not normalised");
  property p_chan3_type;
    chan3_driver_type_o != clk_out_cfg_pkg::DRV_ALT_LVDS;
  endproperty
  a_chan3_type: assert property (p_chan3_type)
    else $error("chan3 type not normalised");
  property p_chan4_type;
    chan4_driver_type_o != clk_out_cfg_pkg::DRV_ALT_LVDS;
  endproperty
  a_chan4_type: assert property (p_chan4_type)
    else $error("chan4 type not normalised");
  property p_cfg_quiet;
    spi_cs_n_i [*8] |-> $stable({chan2_driver_type_o, chan3_driver_type_o,
      chan4_driver_type_o, chan4_edge_rate_o, chan4_supply_select_o, pair_b_supply_select_o});
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("settings changed outside a frame");

  c_neg_on: cover property (chan4_neg_oe_o);
  c_chan2_pulse: cover property ($rose(chan2_o) ##1 !chan2_o);
  c_read: cover property (spi_miso_oe_o);
endmodule : clk_out_cfg_checker

bind clk_out_cfg clk_out_cfg_checker clk_out_cfg_checker_inst (
  .clk_i, .rst_n_i, .spi_cs_n_i, .spi_miso_oe_o, .chan2_o, .chan2_oe_o,
  .chan2_driver_type_o, .chan3_o, .chan3_oe_o, .chan3_driver_type_o,
  .pair_b_supply_select_o, .chan4_pos_o, .chan4_pos_oe_o, .chan4_neg_o,
  .chan4_neg_oe_o, .chan4_driver_type_o, .chan4_edge_rate_o, .chan4_supply_select_o
);

//--- dv/test_clk_out_cfg.sv
// Purpose: Self-checking bench for the output channel configuration block.
// Assumes: Inputs change on the falling clock edge.
// Notes: Periods are measured on the one-cycle output pulses.
`timescale 1ns/100ps
module test_clk_out_cfg;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic spi_sclk_i = 1'b0;
  logic spi_cs_n_i = 1'b1;
  logic spi_mosi_i = 1'b0;
  logic pri_ref_i = 1'b0;
  logic sec_ref_i = 1'b0;
  logic [19:0] chan4_frac_value_i = 20'h00000;
  logic spi_miso_o, spi_miso_oe_o, pair_a_clk_o, chan2_o, chan2_oe_o, chan3_o, chan3_oe_o;
  logic pair_b_supply_select_o, chan4_pos_o, chan4_pos_oe_o, chan4_neg_o, chan4_neg_oe_o;
  logic chan4_edge_rate_o, chan4_supply_select_o;
  logic [1:0] chan2_driver_type_o, chan3_driver_type_o, chan4_driver_type_o;
  int err_count = 0;
  int compares = 0;
  int ref_cnt = 0;
  logic oe_seen = 1'b0;

  clk_out_cfg clk_out_cfg_inst (
    .clk_i, .rst_n_i, .spi_sclk_i, .spi_cs_n_i, .spi_mosi_i, .spi_miso_o, .spi_miso_oe_o,
    .pri_ref_i, .sec_ref_i, .chan4_frac_value_i, .pair_a_clk_o, .chan2_o, .chan2_oe_o,
    .chan2_driver_type_o, .chan3_o, .chan3_oe_o, .chan3_driver_type_o,
    .pair_b_supply_select_o, .chan4_pos_o, .chan4_pos_oe_o, .chan4_neg_o,
    .chan4_neg_oe_o, .chan4_driver_type_o, .chan4_edge_rate_o, .chan4_supply_select_o
  );

  // ----------------------------------------
  // Clock, references and helpers
  // ----------------------------------------
  always #10 clk_i = ~clk_i;

  // Primary reference every 6 cycles, secondary every 10
  always @(negedge clk_i) begin
    ref_cnt <= ref_cnt + 1;
    pri_ref_i <= (ref_cnt % 6) < 3;
    sec_ref_i <= (ref_cnt % 10) < 5;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Mode 0 frame, MSB first, each serial phase five clock cycles
  task automatic spi(input logic rd, input logic [14:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    logic [31:0] f;
    f = {rd, a, d};
    q = 16'h0000;
    @(negedge clk_i);
    spi_cs_n_i = 1'b0;
    for (int i = 0; i < 32; i++) begin
      spi_mosi_i = f[31 - i];
      repeat (5) @(negedge clk_i);
      if (i > 15) q[31 - i] = spi_miso_o;
      if (i == 16) oe_seen = spi_miso_oe_o;
      spi_sclk_i = 1'b1;
      repeat (5) @(negedge clk_i);
      spi_sclk_i = 1'b0;
    end
    repeat (5) @(negedge clk_i);
    spi_cs_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask : spi

  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    logic [15:0] q;
    spi(1'b0, a, d, q);
    check(16'({oe_seen, spi_miso_oe_o}), 16'h0000);
    repeat (3) @(negedge clk_i);
  endtask : wr

  task automatic rd_chk(input logic [14:0] a, input logic [15:0] exp);
    logic [15:0] q;
    spi(1'b1, a, 16'h0000, q);
    check(q, exp);
    check(16'({oe_seen, spi_miso_oe_o}), 16'h0002);
  endtask : rd_chk

  // Cycles between two high samples; zero if sel is 1 and channel 3 ever differs from channel 2
  task automatic period(input int sel, output int p);
    logic s;
    logic bad;
    int n;
    p = 0;
    n = -1;
    bad = 1'b0;
    repeat (20) @(negedge clk_i);
    for (int k = 0; k < 1200 && p == 0; k++) begin
      @(negedge clk_i);
      s = (sel == 0) ? pair_a_clk_o : (sel == 1) ? chan2_o : chan4_pos_o;
      if (sel == 1 && chan3_o !== chan2_o) bad = 1'b1;
      if (n >= 0) n++;
      if (s === 1'b1) begin
        if (n > 0) p = n;
        n = 0;
      end
    end
    if (bad) p = 0;
  endtask : period

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [15:0] m [4];
    logic [14:0] a;
    m = '{clk_out_cfg_pkg::DIV_MASK, clk_out_cfg_pkg::CTL23_MASK,
          clk_out_cfg_pkg::DIV_MASK, clk_out_cfg_pkg::CTL4_MASK};
    for (int i = 0; i < 4; i++) begin
      a = clk_out_cfg_pkg::PAIR01_INTEGER_DIVIDER_OFS + 15'(i);
      rd_chk(a, clk_out_cfg_pkg::REG_RESET);
      wr(a, 16'hFFFF);
      rd_chk(a, m[i]);
    end
    wr(15'h000A, 16'hFFFF);
    rd_chk(15'h000A, 16'h0000);
  endtask : t_regs

  task automatic t_types();
    logic [1:0] c;
    logic [1:0] t;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      t = (c == 2'h1) ? clk_out_cfg_pkg::DRV_LVDS : c;
      wr(clk_out_cfg_pkg::PAIR23_DRIVER_CONTROL_OFS, {7'h00, c, 2'h0, c, 2'h0, c[0]});
      wr(clk_out_cfg_pkg::CHAN4_OUTPUT_CONTROL_OFS, {7'h00, c[1], 3'h0, c, 2'h0, c[0]});
      check(16'({chan2_driver_type_o, chan3_driver_type_o}), 16'({t, t}));
      check(16'(chan4_driver_type_o), 16'(t));
      check(16'({chan4_edge_rate_o, chan4_supply_select_o, pair_b_supply_select_o}),
            16'({c[1], c[0], c[0]}));
    end
  endtask : t_types

  task automatic t_enables();
    logic [1:0] c;
    logic [1:0] s;
    logic lv;
    logic oe;
    wr(clk_out_cfg_pkg::PAIR23_INTEGER_DIVIDER_OFS, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      c = 2'(i >> 2);
      s = 2'(i);
      oe = (c != clk_out_cfg_pkg::EN_OFF);
      lv = c[0];
      wr(clk_out_cfg_pkg::PAIR23_DRIVER_CONTROL_OFS, {7'h00, 2'h0, c, 2'h0, c, 1'b0});
      wr(clk_out_cfg_pkg::CHAN4_OUTPUT_CONTROL_OFS, {8'h00, s, 3'h0, c, 1'b0});
      check(16'({chan2_o, chan2_oe_o, chan3_o, chan3_oe_o}), 16'({lv, oe, lv, oe}));
      check(16'({chan4_pos_o, chan4_pos_oe_o}), 16'({lv & s[0], oe & s[0]}));
      check(16'({chan4_neg_o, chan4_neg_oe_o}), 16'({lv & (&s), oe & (&s)}));
    end
  endtask : t_enables

  task automatic t_div();
    int d [4] = '{0, 1, 2, 255};
    int p;
    wr(clk_out_cfg_pkg::PAIR23_DRIVER_CONTROL_OFS, 16'h0022);
    foreach (d[i]) begin
      wr(clk_out_cfg_pkg::PAIR01_INTEGER_DIVIDER_OFS, 16'(d[i]));
      wr(clk_out_cfg_pkg::PAIR23_INTEGER_DIVIDER_OFS, 16'(d[i]));
      period(0, p);
      check(16'(p), 16'(d[i] + 1));
      period(1, p);
      check(16'(p), 16'(d[i] + 1));
    end
  endtask : t_div

  task automatic t_chan4();
    int tab [7][4] = '{'{0, 0, 0, 1}, '{3, 1, 0, 1}, '{1, 0, 0, 6}, '{2, 0, 0, 10},
                       '{0, 0, 1, 4}, '{0, 1, 1, 6}, '{0, 7, 1, 2}};
    int p;
    chan4_frac_value_i = 20'h80000;
    for (int i = 0; i < 7; i++) begin
      wr(clk_out_cfg_pkg::CHAN4_OUTPUT_CONTROL_OFS,
         {1'b0, 2'(tab[i][0]), 3'(tab[i][1]), 1'(tab[i][2]), 3'h1, 6'h02});
      period(2, p);
      check(16'(p), 16'(tab[i][3]));
    end
  endtask : t_chan4

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    t_regs();
    t_types();
    t_enables();
    t_div();
    t_chan4();
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
endmodule : test_clk_out_cfg
